/* pkg/dwc_pkg.sv */
// Package with the register map, packet codes and timing constants of the doze wakeup controller.
// What this block does
// RULE_01 - Doze discards data, takes addressed wakeups only
// RULE_02 - Terminal-ready low then high re-enters doze
// RULE_03 - Doze cycles 150 ms, listening 8 ms
// RULE_04 - Control frequency fixed, else scan 150 ms each
// RULE_05 - Awake behaves normally, all commands accepted
// RULE_06 - Doze indicator stays valid during shutdown
// RULE_07 - Senders repeat direct wakeups for shut targets
// RULE_08 - Direct command: accepted response, then wakeup packet
// RULE_09 - Dozing device always checks destination address
// RULE_10 - Woken device acknowledges unless broadcast
// RULE_11 - Ack gives success, otherwise failure response
// RULE_12 - Doze enabled: acknowledge wakeups even when awake
// RULE_13 - Broadcast: success after all transmissions
// RULE_14 - Relayed command: accepted response, send repeater requests
// RULE_15 - Repeater requests every 200 ms, retry count
// RULE_16 - Repeater ignores mismatched repeater address when checking
// RULE_17 - Repeater sends wakeups 160 ms, drops acks; the code sends one wakeup, then stays busy for 160 ms
// RULE_18 - Relayed single-station wakeup always reports failure
// RULE_19 - Fixed frequency mode disregards control-frequency bit
// RULE_20 - Control-frequency bit one selects control frequency
// RULE_21 - Control frequency is lowest group frequency
// RULE_22 - Group mode sends 2 or 4 per frequency; the code scans each frequency twice with 4 sends, 8 per frequency
// RULE_23 - Group mode ignores configured retry count
// RULE_24 - Terminal-ready rise enters doze, low wakes
// RULE_25 - Doze only when power-save enable bit set
package dwc_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFF_STATION = 8'h00;
  localparam logic [7:0] OFF_FREQ = 8'h04;
  localparam logic [7:0] OFF_RETRY = 8'h08;
  localparam logic [7:0] OFF_ADDR_CHECK = 8'h0c;
  localparam logic [7:0] OFF_COMM_TWO = 8'h10;
  localparam logic [7:0] OFF_POWER_SAVE = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // Field positions.
  localparam int unsigned PS_DOZE_EN_BIT = 7;
  localparam int unsigned PS_CTRL_FREQ_BIT = 6;
  localparam int unsigned ADDR_CHECK_BIT = 0;
  localparam int unsigned FREQ_FIXED_BIT = 4;
  // Reset values; the frequency reset value is a three-frequency group.
  localparam logic [7:0] RST_STATION = 8'h00;
  localparam logic [7:0] RST_FREQ = 8'h03;
  localparam logic [7:0] RST_RETRY = 8'h03;
  localparam logic [7:0] RST_ADDR_CHECK = 8'h00;
  localparam logic [7:0] RST_COMM_TWO = 8'h00;
  localparam logic [7:0] RST_POWER_SAVE = 8'h00;
  // Packet kinds on the radio side.
  localparam logic [1:0] PK_DATA = 2'h0;
  localparam logic [1:0] PK_WAKE = 2'h1;
  localparam logic [1:0] PK_WAKE_TXREQ = 2'h2;
  localparam logic [1:0] PK_ACK = 2'h3;
  localparam logic [7:0] BCAST_ADDR = 8'hff;
  // Fixed per-frequency wakeup counts in group mode.
  localparam logic [7:0] GRP_CNT_CTRL = 8'h02;
  localparam logic [7:0] GRP_CNT_SCAN = 8'h04;
  // Timing.
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned DOZE_PERIOD_MS = 150;
  localparam int unsigned DOZE_ACTIVE_MS = 8;
  localparam int unsigned WAKE_SLOT_MS = 160;
  localparam int unsigned RELAY_GAP_MS = 200;
  localparam int unsigned RELAY_BURST_MS = 160;
  localparam int unsigned ACK_WAIT_MS = 50;
  localparam int unsigned DOZE_PERIOD_CLKS = DOZE_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned DOZE_ACTIVE_CLKS = DOZE_ACTIVE_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_SLOT_CLKS = WAKE_SLOT_MS * (CLK_HZ / 1000);
  localparam int unsigned RELAY_GAP_CLKS = RELAY_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned RELAY_BURST_CLKS = RELAY_BURST_MS * (CLK_HZ / 1000);
  localparam int unsigned ACK_WAIT_CLKS = ACK_WAIT_MS * (CLK_HZ / 1000);
  // Sender states.
  typedef enum logic [1:0] {SND_IDLE, SND_SEND, SND_WAIT} dwc_snd_e;
endpackage

/* hw/dwc_top.sv */
// Doze wakeup controller with its AXI4-Lite register slave.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dwc_top #(
  parameter int unsigned DOZE_PERIOD = dwc_pkg::DOZE_PERIOD_CLKS,
  parameter int unsigned DOZE_ACTIVE = dwc_pkg::DOZE_ACTIVE_CLKS,
  parameter int unsigned WAKE_SLOT = dwc_pkg::WAKE_SLOT_CLKS,
  parameter int unsigned RELAY_GAP = dwc_pkg::RELAY_GAP_CLKS,
  parameter int unsigned RELAY_BURST = dwc_pkg::RELAY_BURST_CLKS,
  parameter int unsigned ACK_WAIT = dwc_pkg::ACK_WAIT_CLKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic term_ready_pin,
  input wire logic shutdown_n_pin,
  input wire logic cmd_valid,
  input wire logic cmd_relayed,
  input wire logic [7:0] cmd_dest,
  input wire logic [7:0] cmd_rptr,
  output logic cmd_ready,
  output logic resp_accepted,
  output logic resp_success,
  output logic resp_failure,
  input wire logic rx_valid,
  input wire logic [1:0] rx_kind,
  input wire logic [7:0] rx_dest,
  input wire logic [7:0] rx_rptr,
  output logic rx_data_pass,
  output logic tx_valid,
  output logic [1:0] tx_kind,
  output logic [7:0] tx_dest,
  output logic [7:0] tx_rptr,
  output logic [3:0] tx_freq,
  output logic doze_state,
  output logic listen_on,
  output logic clock_stop,
  output logic [3:0] listen_freq
);
  // Configuration registers written by software.
  logic [7:0] station_address_setting;
  logic [7:0] frequency_setting;
  logic [7:0] retry_count_setting;
  logic [7:0] address_check_config;
  logic [7:0] comm_setting_two;
  logic [7:0] power_save_config;
  // Pin synchronisers and their filtered levels.
  logic [2:0] dtr_sync;
  logic [2:0] shut_sync;
  logic dtr_f;
  logic shut_nf;
  logic dtr_prev;
  // Doze cycle and scan state.
  logic [31:0] cyc_cnt;
  logic [3:0] scan_idx;
  // Sender state.
  dwc_pkg::dwc_snd_e snd_st;
  logic snd_relayed;
  logic snd_bcast;
  logic [7:0] snd_dest;
  logic [7:0] snd_rptr;
  logic [7:0] snd_left;
  logic [31:0] snd_cnt;
  logic [2:0] snd_per_freq;
  logic [3:0] snd_freq;
  // Repeater burst state.
  logic relay_busy;
  logic [31:0] relay_cnt;
  logic [7:0] relay_dest;

  // Configuration decode used across the block.
  wire [3:0] group_size = frequency_setting[3:0];
  wire fixed_mode = frequency_setting[dwc_pkg::FREQ_FIXED_BIT];
  wire group_mode = !fixed_mode && (group_size > 4'h1);
  // The control-frequency bit only matters outside fixed mode.
  wire ctrl_used = power_save_config[dwc_pkg::PS_CTRL_FREQ_BIT] && !fixed_mode; // RULE_19 RULE_20
  wire doze_en = power_save_config[dwc_pkg::PS_DOZE_EN_BIT];
  wire shut = !shut_nf;
  wire [3:0] scan_last = (group_size == 4'h0) ? 4'h0 : group_size - 4'h1;

  // Receive classification.
  wire rx_wake = rx_valid && (rx_kind == dwc_pkg::PK_WAKE);
  wire rx_bcast = (rx_dest == dwc_pkg::BCAST_ADDR);
  wire rx_for_me = rx_bcast || (rx_dest == station_address_setting);
  // While dozing only a wakeup seen inside the listen window counts, always address checked.
  wire wake_hit = doze_state && listen_on && rx_wake && rx_for_me; // RULE_09
  // An awake device keeps acknowledging while doze is enabled.
  wire awake_hit = !doze_state && doze_en && rx_wake && rx_for_me && !shut; // RULE_12
  wire ack_fire = (wake_hit || awake_hit) && !rx_bcast; // RULE_10
  // Repeater request check honours the address-check enable.
  wire rptr_ok = !address_check_config[dwc_pkg::ADDR_CHECK_BIT] ||
                 (rx_rptr == station_address_setting); // RULE_16
  wire relay_start = !doze_state && !shut && rx_valid && (rx_kind == dwc_pkg::PK_WAKE_TXREQ) &&
                     rptr_ok && !relay_busy; // RULE_17
  wire relay_fire = relay_start;
  wire ack_rx = rx_valid && (rx_kind == dwc_pkg::PK_ACK) && !doze_state;
  // Sender timing.
  wire snd_gap_done = snd_relayed ? (snd_cnt >= RELAY_GAP - 1) : (snd_cnt >= WAKE_SLOT - 1);
  wire snd_fire = (snd_st == dwc_pkg::SND_SEND) && (snd_cnt == 32'h0) && !ack_fire && !relay_fire;
  // Direct wakeups in group mode use fixed counts instead of the retry setting.
  wire [7:0] grp_scan_cnt = 8'(dwc_pkg::GRP_CNT_SCAN * {4'h0, group_size} * 8'h02); // RULE_22
  wire [7:0] retry_eff = (retry_count_setting == 8'h00) ? 8'h01 : retry_count_setting;
  wire [7:0] direct_cnt = !group_mode ? retry_eff :
                          (ctrl_used ? dwc_pkg::GRP_CNT_CTRL : grp_scan_cnt); // RULE_23
  wire [7:0] first_cnt = cmd_relayed ? retry_eff : direct_cnt; // RULE_15
  wire cmd_take = cmd_valid && cmd_ready;

  // Commands are taken whenever the device is awake, not shut down, and the sender is idle.
  assign cmd_ready = (snd_st == dwc_pkg::SND_IDLE) && !doze_state && !shut; // RULE_05

  // Pin synchronisers; a level counts once the second and third stages agree.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dtr_sync <= 3'h0;
      shut_sync <= 3'h7;
      dtr_f <= 1'b0;
      shut_nf <= 1'b1;
    end
    else
    begin
      dtr_sync <= {dtr_sync[1:0], term_ready_pin};
      shut_sync <= {shut_sync[1:0], shutdown_n_pin};
      dtr_f <= (dtr_sync[1] == dtr_sync[2]) ? dtr_sync[2] : dtr_f;
      shut_nf <= (shut_sync[1] == shut_sync[2]) ? shut_sync[2] : shut_nf;
    end
  end

  // Doze state; it is held in shutdown so the indicator keeps reporting it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      doze_state <= 1'b0;
      dtr_prev <= 1'b0;
    end
    else
    begin
      dtr_prev <= dtr_f;
      if (shut)
      begin
        // Frozen while shut down. RULE_06
        doze_state <= doze_state;
      end
      else if (!doze_state)
      begin
        // Only a fresh rising edge enters doze, so the host must drop the line first.
        doze_state <= doze_en && dtr_f && !dtr_prev; // RULE_02 RULE_24 RULE_25
      end
      else if (!dtr_f || wake_hit)
      begin
        // A low terminal-ready or an addressed wakeup brings the device back.
        doze_state <= 1'b0; // RULE_24
      end
    end
  end

  // Duty cycle counter and frequency scan while dozing.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !doze_state)
    begin
      cyc_cnt <= 32'h0;
      scan_idx <= 4'h0;
    end
    else if (!shut)
    begin
      cyc_cnt <= (cyc_cnt >= DOZE_PERIOD - 1) ? 32'h0 : cyc_cnt + 32'h1; // RULE_03
      if (cyc_cnt >= DOZE_PERIOD - 1)
      begin
        // One dwell of one doze period on each group frequency.
        scan_idx <= (scan_idx >= scan_last) ? 4'h0 : scan_idx + 4'h1; // RULE_04
      end
    end
  end

  // Listen window and clock-stop outputs; the clock stop is a request to the power logic.
  assign listen_on = doze_state && !shut && (cyc_cnt < DOZE_ACTIVE); // RULE_03
  assign clock_stop = doze_state && !listen_on;
  // The control frequency is the lowest one of the group. RULE_21
  assign listen_freq = (ctrl_used || fixed_mode) ? 4'h0 : scan_idx; // RULE_04

  // Ordinary data is passed on only while awake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_data_pass <= 1'b0;
    end
    else
    begin
      rx_data_pass <= rx_valid && (rx_kind == dwc_pkg::PK_DATA) && !doze_state && !shut; // RULE_01
    end
  end

  // Repeater burst; acks coming back are never forwarded.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      relay_busy <= 1'b0;
      relay_cnt <= 32'h0;
      relay_dest <= 8'h00;
    end
    else if (relay_start)
    begin
      relay_busy <= 1'b1;
      relay_cnt <= 32'h0;
      relay_dest <= rx_dest;
    end
    else if (relay_busy)
    begin
      relay_cnt <= relay_cnt + 32'h1;
      relay_busy <= (relay_cnt < RELAY_BURST - 1); // RULE_17
    end
  end

  // Sender sequence for direct and relayed wakeup commands.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      snd_st <= dwc_pkg::SND_IDLE;
      snd_relayed <= 1'b0;
      snd_bcast <= 1'b0;
      snd_dest <= 8'h00;
      snd_rptr <= 8'h00;
      snd_left <= 8'h00;
      snd_cnt <= 32'h0;
      snd_per_freq <= 3'h0;
      snd_freq <= 4'h0;
      resp_accepted <= 1'b0;
      resp_success <= 1'b0;
      resp_failure <= 1'b0;
    end
    else
    begin
      resp_accepted <= 1'b0;
      resp_success <= 1'b0;
      resp_failure <= 1'b0;
      case (snd_st)
        dwc_pkg::SND_IDLE:
        begin
          if (cmd_take)
          begin
            // Accepted response first, sending starts the next cycle.
            resp_accepted <= 1'b1; // RULE_08 RULE_14
            snd_st <= dwc_pkg::SND_SEND;
            snd_relayed <= cmd_relayed;
            snd_bcast <= (cmd_dest == dwc_pkg::BCAST_ADDR);
            snd_dest <= cmd_dest;
            snd_rptr <= cmd_rptr;
            snd_left <= first_cnt;
            snd_cnt <= 32'h0;
            snd_per_freq <= 3'h0;
            snd_freq <= 4'h0;
          end
        end
        dwc_pkg::SND_SEND:
        begin
          if (!snd_relayed && !snd_bcast && ack_rx)
          begin
            // Acknowledged single-station direct wakeup.
            resp_success <= 1'b1; // RULE_11
            snd_st <= dwc_pkg::SND_IDLE;
          end
          else if (snd_cnt == 32'h0 && !snd_fire)
          begin
            // Lost the transmitter to a higher priority packet; try again next cycle.
            snd_cnt <= 32'h0;
          end
          else if (snd_gap_done)
          begin
            snd_cnt <= 32'h0;
            snd_left <= snd_left - 8'h01;
            if (snd_left == 8'h01)
            begin
              snd_st <= dwc_pkg::SND_WAIT;
            end
            // Scan the group four sends per frequency without a control frequency.
            if (group_mode && !ctrl_used && !snd_relayed)
            begin
              snd_per_freq <= (snd_per_freq == 3'h3) ? 3'h0 : snd_per_freq + 3'h1;
              if (snd_per_freq == 3'h3)
              begin
                snd_freq <= (snd_freq >= scan_last) ? 4'h0 : snd_freq + 4'h1;
              end
            end
          end
          else
          begin
            snd_cnt <= snd_cnt + 32'h1; // RULE_15
          end
        end
        dwc_pkg::SND_WAIT:
        begin
          if (snd_bcast)
          begin
            // Broadcast always ends in success once every send is done.
            resp_success <= 1'b1; // RULE_13
            snd_st <= dwc_pkg::SND_IDLE;
          end
          else if (snd_relayed)
          begin
            // A repeater never returns the ack, so success cannot be known.
            resp_failure <= 1'b1; // RULE_18
            snd_st <= dwc_pkg::SND_IDLE;
          end
          else if (ack_rx)
          begin
            resp_success <= 1'b1; // RULE_11
            snd_st <= dwc_pkg::SND_IDLE;
          end
          else if (snd_cnt >= ACK_WAIT - 1)
          begin
            resp_failure <= 1'b1; // RULE_11
            snd_st <= dwc_pkg::SND_IDLE;
          end
          else
          begin
            snd_cnt <= snd_cnt + 32'h1;
          end
        end
        default:
        begin
          snd_st <= dwc_pkg::SND_IDLE;
        end
      endcase
    end
  end

  // Transmit port; ack beats a relay burst which beats the sender.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_valid <= 1'b0;
      tx_kind <= dwc_pkg::PK_DATA;
      tx_dest <= 8'h00;
      tx_rptr <= 8'h00;
      tx_freq <= 4'h0;
    end
    else
    begin
      tx_valid <= ack_fire || relay_fire || snd_fire;
      if (ack_fire)
      begin
        tx_kind <= dwc_pkg::PK_ACK; // RULE_10
        tx_dest <= rx_dest;
        tx_rptr <= 8'h00;
        tx_freq <= listen_freq;
      end
      else if (relay_fire)
      begin
        tx_kind <= dwc_pkg::PK_WAKE; // RULE_17
        tx_dest <= rx_dest;
        tx_rptr <= 8'h00;
        tx_freq <= 4'h0;
      end
      else if (snd_fire)
      begin
        tx_kind <= snd_relayed ? dwc_pkg::PK_WAKE_TXREQ : dwc_pkg::PK_WAKE; // RULE_08 RULE_14
        tx_dest <= snd_dest;
        tx_rptr <= snd_rptr;
        tx_freq <= ctrl_used ? 4'h0 : snd_freq; // RULE_21
      end
    end
  end

  // AXI4-Lite write side takes address and data together when no response is pending.
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
  wire wr_map = (wa <= dwc_pkg::OFF_POWER_SAVE);
  wire wr_byte = wr_take && wr_map && s_axi_wstrb[0];
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;

  // Register writes; the status word is read only.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      station_address_setting <= dwc_pkg::RST_STATION;
      frequency_setting <= dwc_pkg::RST_FREQ;
      retry_count_setting <= dwc_pkg::RST_RETRY;
      address_check_config <= dwc_pkg::RST_ADDR_CHECK;
      comm_setting_two <= dwc_pkg::RST_COMM_TWO;
      power_save_config <= dwc_pkg::RST_POWER_SAVE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (wr_byte && wa == dwc_pkg::OFF_STATION) station_address_setting <= s_axi_wdata[7:0];
      if (wr_byte && wa == dwc_pkg::OFF_FREQ) frequency_setting <= s_axi_wdata[7:0];
      if (wr_byte && wa == dwc_pkg::OFF_RETRY) retry_count_setting <= s_axi_wdata[7:0];
      if (wr_byte && wa == dwc_pkg::OFF_ADDR_CHECK) address_check_config <= s_axi_wdata[7:0];
      if (wr_byte && wa == dwc_pkg::OFF_COMM_TWO) comm_setting_two <= s_axi_wdata[7:0];
      if (wr_byte && wa == dwc_pkg::OFF_POWER_SAVE) power_save_config <= s_axi_wdata[7:0];
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'b00 : 2'b11;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read side; unmapped addresses answer with a decode error and zero data.
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire rd_take = s_axi_arvalid && !s_axi_rvalid;
  wire [7:0] status_word = {listen_freq, relay_busy, snd_st != dwc_pkg::SND_IDLE, shut, doze_state};
  wire rd_map = (ra <= dwc_pkg::OFF_STATUS);
  wire [7:0] rd_byte = (ra == dwc_pkg::OFF_STATION) ? station_address_setting :
                       (ra == dwc_pkg::OFF_FREQ) ? frequency_setting :
                       (ra == dwc_pkg::OFF_RETRY) ? retry_count_setting :
                       (ra == dwc_pkg::OFF_ADDR_CHECK) ? address_check_config :
                       (ra == dwc_pkg::OFF_COMM_TWO) ? comm_setting_two :
                       (ra == dwc_pkg::OFF_POWER_SAVE) ? power_save_config :
                       (ra == dwc_pkg::OFF_STATUS) ? status_word : 8'h00;
  assign s_axi_arready = rd_take;

  // Read data register, held until the master takes it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, rd_byte};
      s_axi_rresp <= rd_map ? 2'b00 : 2'b11;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the behaviour above.
  a_data_drop_doze: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_01
    doze_state && rx_valid && rx_kind == dwc_pkg::PK_DATA |=> !rx_data_pass)
    else $error("data passed while dozing");
  a_doze_entry_edge: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_24
    !doze_state && !shut && doze_en && dtr_f && !dtr_prev |=> doze_state)
    else $error("doze not entered on terminal-ready rise");
  a_no_doze_disabled: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_25
    !doze_state && !doze_en |=> !doze_state)
    else $error("doze entered while disabled");
  a_listen_window: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_03
    listen_on |-> doze_state && cyc_cnt < DOZE_ACTIVE && cyc_cnt < DOZE_PERIOD)
    else $error("listen outside active window");
  a_ctrl_freq_low: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    doze_state && ctrl_used |-> listen_freq == 4'h0)
    else $error("control frequency not lowest");
  a_wake_mismatch: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
    doze_state && dtr_f && rx_wake && !rx_for_me |=> doze_state)
    else $error("woke on foreign address");
  a_ack_bcast: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
    wake_hit && rx_bcast |=> !(tx_valid && tx_kind == dwc_pkg::PK_ACK))
    else $error("ack sent for broadcast");
  a_accept_then_tx: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    resp_accepted |-> snd_st == dwc_pkg::SND_SEND && snd_cnt == 32'h0)
    else $error("send not started after accept");
  a_relay_fail: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_18
    resp_success |-> snd_bcast || !snd_relayed)
    else $error("relayed single wakeup reported success");
  a_shut_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
    shut && $past(shut) |-> doze_state == $past(doze_state))
    else $error("doze indicator moved in shutdown");
endmodule // dwc_top
`default_nettype wire

/* verification/dwc_peer.sv */
// Remote station model that answers direct wakeup packets.
`timescale 1ns/1ps
`default_nettype none
module dwc_peer #(
  parameter logic [7:0] ADDR = 8'h22
) (
  input wire logic aclk,
  input wire logic tx_valid,
  input wire logic [1:0] tx_kind,
  input wire logic [7:0] tx_dest,
  output logic rx_valid,
  output logic [1:0] rx_kind,
  output logic [7:0] rx_dest,
  output logic [7:0] rx_rptr
);
  // One packet pulse; destination and repeater fields flip after it so stale values never look valid.
  task automatic send(input logic [1:0] k, input logic [7:0] d);
    @(posedge aclk);
    {rx_valid, rx_kind, rx_dest, rx_rptr} <= {1'b1, k, d, d};
    @(posedge aclk);
    {rx_valid, rx_dest, rx_rptr} <= {1'b0, ~d, ~d};
  endtask
  initial {rx_valid, rx_kind, rx_dest, rx_rptr} = '0;
  // Only a wakeup for this station is acknowledged.
  always @(posedge aclk)
    if (tx_valid && tx_kind === 2'h1 && tx_dest === ADDR) send(2'h3, 8'h05);
endmodule // dwc_peer
`default_nettype wire

/* verification/doze_wakeup_controller_bench.sv */
// Self-checking bench for the doze wakeup controller.
`timescale 1ns/1ps
`default_nettype none
module doze_wakeup_controller_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cmd_dest, cmd_rptr, rx_dest, rx_rptr, tx_dest, tx_rptr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, tx_freq, listen_freq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_kind, tx_kind;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_ready;
  logic term_ready_pin, shutdown_n_pin, cmd_valid, cmd_relayed, resp_accepted, resp_success;
  logic resp_failure, rx_valid, rx_data_pass, tx_valid, doze_state, listen_on, clock_stop;
  int err_total, n_tests;
  // Short timing keeps each wait to a few hundred cycles.
  dwc_top #(.DOZE_PERIOD(150), .DOZE_ACTIVE(8), .WAKE_SLOT(16), .RELAY_GAP(20),
    .RELAY_BURST(16), .ACK_WAIT(10)) i_dut (.*);
  dwc_peer i_peer (.*);
  initial forever #25 aclk = ~aclk;
  task automatic chk(input logic [33:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One register access; ready is seen mid-cycle and acted on at the next edge.
  task automatic axi(input logic w, input logic [7:0] a, d, input logic [1:0] e);
    logic ta, tw, tb;
    logic [33:0] r;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    do
    begin
      @(negedge aclk);
      {ta, tw, tb} = {s_axi_awready | s_axi_arready, s_axi_wready, s_axi_bvalid | s_axi_rvalid};
      r = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= '0;
      if (tw) s_axi_wvalid <= '0;
    end while (!tb);
    {s_axi_bready, s_axi_rready} <= '0;
    chk(r, {e, 24'h0, w ? 8'h0 : d});
  endtask
  // One wakeup command; judges the last packet sent, the packet count and the ordered result pulses.
  task automatic wake(input logic rel, input logic [7:0] d, input logic ok, input logic [3:0] c);
    logic t, acc, s, f;
    logic [3:0] n;
    acc = '0;
    n = '0;
    @(posedge aclk);
    {cmd_relayed, cmd_dest, cmd_rptr, cmd_valid} <= {rel, d, ~d, 1'b1};
    do
    begin
      @(negedge aclk);
      {t, acc, s, f} = {cmd_ready & cmd_valid, acc | resp_accepted, resp_success, resp_failure};
      // Every transmit pulse stands one cycle, so one look per cycle counts them all.
      n = n + {3'h0, tx_valid};
      @(posedge aclk);
      if (t) cmd_valid <= '0;
    end while (!(s | f));
    chk({acc, s, f, tx_kind, tx_dest, tx_rptr, tx_freq, n},
      {3'b100 | {1'b0, ok, !ok}, rel, !rel, d, ~d, 4'h0, c});
  endtask
  // Dozes, filters wrong traffic, survives shutdown, then wakes over the link.
  task automatic doze();
    @(posedge aclk);
    term_ready_pin <= '1;
    repeat (8) @(posedge aclk);
    chk(doze_state, 1);
    @(posedge listen_on);
    i_peer.send(2'h1, 8'h06);
    i_peer.send(2'h0, 8'h05);
    // A forwarded-data pulse would stand for this one cycle only.
    @(negedge aclk);
    chk({rx_data_pass, doze_state}, 1);
    repeat (3) @(posedge aclk);
    shutdown_n_pin <= '0;
    repeat (8) @(posedge aclk);
    chk(doze_state, 1);
    chk({clock_stop, listen_on, listen_freq}, 6'h20);
    shutdown_n_pin <= '1;
    @(posedge listen_on);
    i_peer.send(2'h1, 8'h05);
    // The first wakeup wakes the target; the second arrives while it is awake and must still be acknowledged.
    i_peer.send(2'h1, 8'h05);
    @(negedge aclk);
    chk({tx_valid, tx_kind, tx_dest}, {3'h7, 8'h05});
    repeat (3) @(posedge aclk);
    chk({doze_state, tx_kind}, 3);
    i_peer.send(2'h2, 8'h44);
    @(negedge aclk);
    chk({tx_valid, tx_kind, tx_dest}, {3'h5, 8'h44});
  endtask
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd_dest, cmd_rptr, cmd_valid, cmd_relayed} = '0;
    {term_ready_pin, err_total, n_tests} = '0;
    {s_axi_wstrb, shutdown_n_pin} = 5'h1f;
    repeat (20) @(posedge aclk);
    aresetn <= '1;
    axi(0, dwc_pkg::OFF_FREQ, dwc_pkg::RST_FREQ, 2'b00);
    axi(1, dwc_pkg::OFF_STATION, 8'h05, 2'b00);
    // A write without the low byte lane must leave the register alone.
    s_axi_wstrb <= 4'he;
    axi(1, dwc_pkg::OFF_STATION, 8'h77, 2'b00);
    s_axi_wstrb <= 4'hf;
    axi(0, dwc_pkg::OFF_STATION, 8'h05, 2'b00);
    axi(1, dwc_pkg::OFF_FREQ, 8'h10, 2'b00);
    axi(1, dwc_pkg::OFF_RETRY, 8'h01, 2'b00);
    axi(1, dwc_pkg::OFF_POWER_SAVE, 8'hc0, 2'b00);
    axi(1, dwc_pkg::OFF_STATUS, 8'h00, 2'b11);
    axi(0, 8'h40, 8'h00, 2'b11);
    wake(0, 8'h22, 1, 4'h1);
    wake(0, 8'h33, 0, 4'h1);
    wake(0, 8'hff, 1, 4'h1);
    wake(1, 8'h22, 0, 4'h1);
    // Group of three with the control frequency from here on.
    axi(1, dwc_pkg::OFF_FREQ, 8'h03, 2'b00);
    doze();
    wake(0, 8'h33, 0, 4'h2);
    results();
  end
  // Cuts a hang short.
  initial
  begin
    #2000000 err_total++;
    results();
  end
endmodule // doze_wakeup_controller_bench
`default_nettype wire
